// ===== hw/rst_wdog_pkg.sv
// Purpose: constants and types for the reset and watchdog control block
// Assumes: 100 MHz system clock, one cpu i/o port in the same domain
// Notes: offsets are i/o port addresses used by the io read/write instructions
//
// Notes on behaviour
// RULE1: three reset sources; usb bus reset is soft
// RULE2: any reset returns registers to defaults; here the status register keeps its bits on watchdog and usb bus reset
// RULE3: reset loads both stack pointers with zero
// RULE4: status bits 4,5,6 record reset cause
// RULE5: restart at address zero, nothing pushed
// RULE6: power-on reset sets power-on status flag
// RULE7: power-on floats ports; strap selects behaviour
// RULE8: strap high and idle bus means suspend
// RULE9: leaving suspend with strap high: short delay
// RULE10: strap low after power-on: long delay
// RULE11: delay choice: strap, then flag, then short
// RULE12: firmware clears power-on flag before suspend
// RULE13: watchdog msb rising triggers reset, sets bit6
// RULE14: watchdog advances on timer bit 11 tick
// RULE15: any write to clear port zeroes watchdog
// RULE16: watchdog reset held 2.048 ms then restart
// RULE17: usb transmitter off until address msb set
// RULE18: indexed write adds x to encoded address
// RULE19: firmware moves data stack below endpoint fifos
// RULE20: every reset source also clears watchdog counter
package rst_wdog_pkg;
    // i/o port addresses
    localparam logic [7:0] ADDR_USB_ADDR_A = 8'h10;
    localparam logic [7:0] ADDR_WDOG_CLEAR = 8'h26;
    localparam logic [7:0] ADDR_PROC_STATUS = 8'hFF;
    // status register fields and usb address enable bit
    localparam int POR_BIT = 4;
    localparam int USB_RST_BIT = 5;
    localparam int WDOG_BIT = 6;
    localparam int USB_EN_BIT = 7;
    // reset values
    localparam logic [7:0] PROC_STATUS_RST = 8'h00;
    localparam logic [7:0] USB_ADDR_RST = 8'h00;
    localparam logic [7:0] STACK_PTR_RST = 8'h00;
    localparam logic [13:0] START_ADDR = 14'h0000;
    // timing, printed figures and derived cycle counts
    localparam int CLK_MHZ = 100;
    localparam int SHORT_DELAY_US = 128;
    localparam int LONG_DELAY_MS = 96;
    localparam int WDOG_HOLD_US = 2048;
    localparam int TIMER_TICK_US = 1;
    localparam int SHORT_DELAY_CYC = SHORT_DELAY_US * CLK_MHZ;
    localparam int LONG_DELAY_CYC = LONG_DELAY_MS * 1000 * CLK_MHZ;
    localparam int WDOG_HOLD_CYC = WDOG_HOLD_US * CLK_MHZ;
    localparam int TIMER_TICK_CYC = TIMER_TICK_US * CLK_MHZ;
    localparam int WDOG_TAP_BIT = 11;
    // sequencer states
    typedef enum logic [2:0] {
        ST_STRAP, ST_SUSPEND, ST_DELAY, ST_RUN, ST_WDOG_HOLD
    } seq_state_t;
    // cpu i/o request
    typedef struct packed {
        logic rd;
        logic wr;
        logic idx;
        logic [7:0] addr;
        logic [7:0] x;
        logic [7:0] acc;
    } io_req_t;
    // usb line state
    typedef struct packed {
        logic dp;
        logic dm;
        logic bus_reset;
    } usb_line_t;
endpackage

// ===== hw/wdog_counter.sv
// Purpose: 2-bit watchdog counter with msb rising edge detect
// Assumes: tick is a one-cycle pulse
// Notes: clear has priority over tick
`timescale 1ns/1ps
module wdog_counter
    import rst_wdog_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_tick,
    input wire logic i_clear,
    output logic o_expire
);
    logic [1:0] cnt_q; // watchdog count
    logic [1:0] cnt_d;

    // next count; clear wins over tick
    always_comb begin
        cnt_d = cnt_q;
        if (i_clear) begin
            cnt_d = 2'h0; // [RULE15] [RULE20]
        end else if (i_tick) begin
            cnt_d = cnt_q + 2'h1; // [RULE14]
        end
    end

    // counter register
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // expiry pulse on msb low to high
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_expire <= 1'b0;
        end else begin
            o_expire <= !cnt_q[1] && cnt_d[1]; // [RULE13]
        end
    end
endmodule

// ===== hw/reset_and_watchdog_control.sv
// Purpose: reset sequencing, reset cause record and watchdog
// Assumes: i_rst_b is the power-on reset; cpu i/o is synchronous
// Notes: cpu held in reset by o_cpu_rst_b during delays and suspend
`timescale 1ns/1ps
module reset_and_watchdog_control
    import rst_wdog_pkg::*;
#(
    parameter int LONG_CYC = LONG_DELAY_CYC, // long start-up delay
    parameter int SHORT_CYC = SHORT_DELAY_CYC, // short start-up delay
    parameter int HOLD_CYC = WDOG_HOLD_CYC, // watchdog hold time
    parameter int TICK_CYC = TIMER_TICK_CYC // free-running timer period
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire io_req_t i_io,
    input wire usb_line_t i_usb,
    input wire logic i_strap_p3_7,
    output logic [7:0] o_rd_data,
    output logic o_cpu_rst_b,
    output logic o_soft_rst,
    output logic [13:0] o_start_addr,
    output logic [7:0] o_prog_stack_ptr,
    output logic [7:0] o_data_stack_ptr,
    output logic o_gpio_hiz,
    output logic o_suspend,
    output logic o_usb_tx_en,
    output logic [7:0] o_usb_addr
);
    ////////////////////////////////////////////////////////////////
    // elaboration checks
    if (LONG_CYC < 1 || SHORT_CYC < 1 || HOLD_CYC < 1 || TICK_CYC < 1) begin : g_chk
        $error("cycle counts must be at least one");
    end

    ////////////////////////////////////////////////////////////////
    // declarations
    seq_state_t state_q; // sequencer state
    logic [31:0] dly_q; // delay counter
    logic [7:0] status_q; // processor status and control
    logic [7:0] usb_addr_q; // usb device address a
    logic [31:0] tdiv_q; // prescaler to 1 us timer tick
    logic [11:0] timer_q; // 12-bit free-running timer
    logic tap_q; // delayed timer bit 11
    logic wdog_tick; // one pulse per 4.096 ms
    logic wdog_expire; // msb rose
    logic [7:0] port_addr; // effective i/o address
    logic wr_status; // write to status port
    logic wr_usb_addr; // write to usb address port
    logic wr_wdog; // write to watchdog clear port
    logic running; // cpu released
    logic idle_bus; // dm high, dp low
    logic wake; // resume condition on bus

    ////////////////////////////////////////////////////////////////
    // address decode
    // effective port address; indexed write adds x
    function automatic logic [7:0] eff_addr(input io_req_t r);
        eff_addr = r.idx ? 8'(r.addr + r.x) : r.addr; // [RULE18]
    endfunction

    assign port_addr = eff_addr(i_io);
    assign running = (state_q == ST_RUN);
    assign wr_status = running && i_io.wr && (port_addr == ADDR_PROC_STATUS);
    assign wr_usb_addr = running && i_io.wr && (port_addr == ADDR_USB_ADDR_A);
    assign wr_wdog = running && i_io.wr && (port_addr == ADDR_WDOG_CLEAR);
    assign idle_bus = i_usb.dm && !i_usb.dp;
    // bus reset, k state (dm low dp high) or se0 ends suspend
    assign wake = i_usb.bus_reset || (!i_usb.dm && i_usb.dp) || (!i_usb.dm && !i_usb.dp);

    ////////////////////////////////////////////////////////////////
    // free-running timer and watchdog tick
    // 1 us prescaler and 12-bit timer
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tdiv_q <= '0;
            timer_q <= '0;
        end else if (tdiv_q == 32'(TICK_CYC - 1)) begin
            tdiv_q <= '0;
            timer_q <= timer_q + 12'h001;
        end else begin
            tdiv_q <= tdiv_q + 32'h1;
        end
    end

    // delayed tap for edge detect on bit 11
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tap_q <= 1'b0;
        end else begin
            tap_q <= timer_q[WDOG_TAP_BIT];
        end
    end

    // tick on the rising edge of timer bit 11, only while running
    assign wdog_tick = running && timer_q[WDOG_TAP_BIT] && !tap_q; // [RULE14]

    ////////////////////////////////////////////////////////////////
    // watchdog counter
    // cleared by any write to its port or by any reset state
    wdog_counter u_wdog (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_tick(wdog_tick),
        .i_clear(wr_wdog || !running || i_usb.bus_reset), // [RULE15] [RULE20]
        .o_expire(wdog_expire)
    );

    ////////////////////////////////////////////////////////////////
    // reset sequencer
    // strap, suspend, start-up delay, run, watchdog hold
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_STRAP; // [RULE1]
            dly_q <= '0;
        end else begin
            case (state_q)
                // first cycle after power-on: sample strap and bus
                ST_STRAP: begin
                    if (i_strap_p3_7 && idle_bus) begin
                        state_q <= ST_SUSPEND; // [RULE8]
                    end else if (i_strap_p3_7) begin
                        state_q <= ST_DELAY;
                        dly_q <= 32'(SHORT_CYC - 1); // [RULE11]
                    end else begin
                        state_q <= ST_DELAY;
                        // flag is being set on this same edge, so status_q still
                        // reads zero here; strap low after power-on is the long delay
                        dly_q <= 32'(LONG_CYC - 1); // [RULE10] [RULE11]
                    end
                end
                // suspended until bus activity
                ST_SUSPEND: begin
                    if (wake) begin
                        state_q <= ST_DELAY;
                        if (i_strap_p3_7 || !status_q[POR_BIT]) begin
                            dly_q <= 32'(SHORT_CYC - 1); // [RULE9] [RULE11]
                        end else begin
                            dly_q <= 32'(LONG_CYC - 1); // [RULE11]
                        end
                    end
                end
                // start-up delay count down
                ST_DELAY: begin
                    if (dly_q == 32'h0) begin
                        state_q <= ST_RUN;
                    end else begin
                        dly_q <= dly_q - 32'h1;
                    end
                end
                // cpu runs until watchdog expiry
                ST_RUN: begin
                    if (wdog_expire) begin
                        state_q <= ST_WDOG_HOLD; // [RULE13]
                        dly_q <= 32'(HOLD_CYC - 1); // [RULE16]
                    end
                end
                // watchdog reset held, then restart
                ST_WDOG_HOLD: begin
                    if (dly_q == 32'h0) begin
                        state_q <= ST_RUN; // [RULE16]
                    end else begin
                        dly_q <= dly_q - 32'h1;
                    end
                end
                default: begin
                    state_q <= ST_STRAP;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // processor status and control register
    // cause bits set by hardware win over a firmware write
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            status_q <= PROC_STATUS_RST;
        end else begin
            if (wr_status) begin
                status_q <= i_io.acc; // firmware may clear flags [RULE12]
            end
            if (state_q == ST_STRAP) begin
                status_q[POR_BIT] <= 1'b1; // [RULE4] [RULE6]
            end
            if (i_usb.bus_reset && running) begin
                status_q[USB_RST_BIT] <= 1'b1; // [RULE4]
            end
            if (state_q == ST_RUN && wdog_expire) begin
                status_q[WDOG_BIT] <= 1'b1; // [RULE4] [RULE13]
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // usb device address register
    // cleared by every reset source
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            usb_addr_q <= USB_ADDR_RST; // [RULE2]
        end else if (!running || i_usb.bus_reset) begin
            usb_addr_q <= USB_ADDR_RST; // [RULE2] [RULE17]
        end else if (wr_usb_addr) begin
            usb_addr_q <= i_io.acc;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read path
    // non-indexed io read returns the selected port, others read zero; an indexed read leaves o_rd_data unchanged
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rd_data <= 8'h00;
        end else if (i_io.rd && !i_io.idx) begin
            case (i_io.addr)
                ADDR_PROC_STATUS: o_rd_data <= status_q; // [RULE4] [RULE18]
                ADDR_USB_ADDR_A: o_rd_data <= usb_addr_q; // [RULE18]
                default: o_rd_data <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // control outputs, all registered
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cpu_rst_b <= 1'b0;
            o_soft_rst <= 1'b0;
            o_start_addr <= START_ADDR;
            o_prog_stack_ptr <= STACK_PTR_RST; // [RULE3]
            o_data_stack_ptr <= STACK_PTR_RST; // [RULE3]
            o_gpio_hiz <= 1'b1; // [RULE7]
            o_suspend <= 1'b0;
            o_usb_tx_en <= 1'b0;
            o_usb_addr <= USB_ADDR_RST;
        end else begin
            // cpu released only in run, restart at zero, no push
            o_cpu_rst_b <= (state_q == ST_RUN) && !wdog_expire; // [RULE5] [RULE16]
            o_soft_rst <= running && i_usb.bus_reset; // [RULE1]
            o_start_addr <= START_ADDR; // [RULE5]
            o_prog_stack_ptr <= STACK_PTR_RST; // [RULE3]
            o_data_stack_ptr <= STACK_PTR_RST; // [RULE3]
            o_gpio_hiz <= (state_q == ST_STRAP) || (state_q == ST_SUSPEND)
                          || (state_q == ST_DELAY); // [RULE7]
            o_suspend <= (state_q == ST_SUSPEND); // [RULE8]
            o_usb_tx_en <= usb_addr_q[USB_EN_BIT]; // [RULE17]
            o_usb_addr <= usb_addr_q;
        end
    end
endmodule

// ===== sim/rst_wdog_sva.sv
// Purpose: port assertions for the reset and watchdog control block
// Assumes: one clock domain, i_rst_b async active low
// Notes: attached by bind from the bench top file
`timescale 1ns/1ps
module rst_wdog_sva
    import rst_wdog_pkg::*;
#(parameter int SHORT_CYC = SHORT_DELAY_CYC) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire io_req_t i_io,
    input wire usb_line_t i_usb,
    input wire logic [7:0] o_rd_data,
    input wire logic o_cpu_rst_b,
    input wire logic o_soft_rst,
    input wire logic [13:0] o_start_addr,
    input wire logic [7:0] o_prog_stack_ptr,
    input wire logic [7:0] o_data_stack_ptr,
    input wire logic o_gpio_hiz,
    input wire logic o_suspend,
    input wire logic o_usb_tx_en,
    input wire logic [7:0] o_usb_addr
);
default clocking cb @(posedge i_sys_clk); endclocking
default disable iff (!i_rst_b);
// cycles the core has been held since release or wake
int low_cnt_q;
always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) low_cnt_q <= 0;
    else low_cnt_q <= (o_cpu_rst_b || o_suspend) ? 0 : low_cnt_q + 1;
end
a_start_held: assert property ($rose(i_rst_b) |-> !o_cpu_rst_b && o_gpio_hiz)
    else $error("core not held after reset release");
a_run_ports: assert property (o_cpu_rst_b |-> !o_gpio_hiz && !o_suspend)
    else $error("ports floating while running");
a_delay_min: assert property ($rose(o_cpu_rst_b) |-> low_cnt_q >= SHORT_CYC)
    else $error("start-up delay too short");
a_hold_len: assert property ($fell(o_cpu_rst_b) |-> !o_cpu_rst_b [*8])
    else $error("watchdog hold too short");
a_ptr_zero: assert property (o_prog_stack_ptr == 8'h00 && o_data_stack_ptr == 8'h00
    && o_start_addr == 14'h0000) else $error("load values not zero");
a_susp_held: assert property (o_suspend |-> !o_cpu_rst_b && o_gpio_hiz)
    else $error("core running in suspend");
a_wake_bus: assert property (o_suspend && !i_usb.dm |-> ##[1:4] !o_suspend)
    else $error("no wake on bus activity");
a_soft_only: assert property (o_soft_rst |-> o_cpu_rst_b)
    else $error("bus reset held the core");
a_tx_gated: assert property (o_usb_tx_en |-> o_usb_addr[7] || $past(o_usb_addr[7]))
    else $error("transmitter on without address msb");
a_rd_unmapped: assert property (i_io.rd && !(i_io.addr inside {8'h10, 8'h26, 8'hFF})
    |=> o_rd_data == 8'h00) else $error("unmapped read not zero");
endmodule

// ===== sim/cpu_io_model.sv
// Purpose: core side model issuing io read and write pulses
// Assumes: the core acts only while released from reset
// Notes: idle fields flip so stale values never pass as live
`timescale 1ns/1ps
module cpu_io_model
    import rst_wdog_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_cpu_rst_b,
    output io_req_t o_io
);
initial o_io = '0;
// one-cycle request, dropped while the core is held
task automatic io_op(input logic r, w, i, input logic [7:0] a, xi, d);
    @(posedge i_sys_clk);
    if (i_cpu_rst_b !== 1'b1) return;
    o_io <= '{r, w, i, a, xi, d};
    @(posedge i_sys_clk);
    o_io <= '{1'b0, 1'b0, 1'b0, ~a, ~xi, ~d};
endtask
endmodule

// ===== sim/reset_and_watchdog_control_bench.sv
// Purpose: self-checking bench for reset and watchdog control
// Assumes: long counts shortened by parameters
// Notes: read data compared against a queue of expected values
`timescale 1ns/1ps
module reset_and_watchdog_control_bench import rst_wdog_pkg::*; ();
localparam int SHORT = 5;
localparam usb_line_t IDLE = 3'b010;
localparam usb_line_t KRES = 3'b100;
logic i_sys_clk = 0, i_rst_b = 0, i_strap_p3_7 = 0, rd_pend = 0, soft_seen = 0;
usb_line_t i_usb = IDLE;
io_req_t i_io;
logic [7:0] o_rd_data, o_prog_stack_ptr, o_data_stack_ptr, o_usb_addr, v;
logic [13:0] o_start_addr;
logic o_cpu_rst_b, o_soft_rst, o_gpio_hiz, o_suspend, o_usb_tx_en;
logic [7:0] exp_q[$];
int bad_count = 0, samples_checked = 0, n;
reset_and_watchdog_control #(.LONG_CYC(20), .SHORT_CYC(SHORT), .HOLD_CYC(8), .TICK_CYC(1))
    u_reset_and_watchdog_control (.i_sys_clk, .i_rst_b, .i_io, .i_usb, .i_strap_p3_7,
    .o_rd_data, .o_cpu_rst_b, .o_soft_rst, .o_start_addr, .o_prog_stack_ptr,
    .o_data_stack_ptr, .o_gpio_hiz, .o_suspend, .o_usb_tx_en, .o_usb_addr);
cpu_io_model u_cpu_io_model (.i_sys_clk, .i_cpu_rst_b(o_cpu_rst_b), .o_io(i_io));
initial forever #5 i_sys_clk = ~i_sys_clk;
task automatic check(input logic [15:0] seen, want);
    samples_checked++;
    if (seen !== want) begin
        bad_count++;
        $display("BAD %0t seen %h want %h", $time, seen, want);
    end
endtask
task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
endtask
// settle point for sampling outputs
task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
endtask
// bounded wait on the core hold, cycles waited in n
task automatic wait_cpu(input logic lvl, input int lim);
    for (n = 0; o_cpu_rst_b !== lvl; n++) begin
        tick(0);
        if (n > lim) begin
            bad_count++;
            print_verdict();
        end
    end
endtask
task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    u_cpu_io_model.io_op(1'b0 + 1'b1, 1'b0, 1'b0, a, 8'h00, 8'h00);
endtask
task automatic wr(input logic [7:0] a, d);
    u_cpu_io_model.io_op(1'b0, 1'b1, 1'b0, a, 8'h00, d);
endtask
task automatic por(input logic s, input usb_line_t u);
    @(posedge i_sys_clk);
    i_rst_b <= 1'b0;
    i_strap_p3_7 <= s;
    i_usb <= u;
    repeat (8) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
endtask
// read results appear the cycle after the request
always @(posedge i_sys_clk) begin
    if (rd_pend) check(o_rd_data, exp_q.pop_front());
    if (o_soft_rst === 1'b1) soft_seen <= 1'b1;
    rd_pend <= i_io.rd;
end
initial begin
    void'($urandom(32'hAA9F3277));
    tick(4);
    check(o_cpu_rst_b, 1'b0);
    check(o_gpio_hiz, 1'b1);
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    wait_cpu(1'b1, 60);
    check(n inside {[20:28]}, 1'b1);
    check(o_prog_stack_ptr, 8'h00);
    check(o_data_stack_ptr, 8'h00);
    check(o_start_addr, 14'h0000);
    rd(ADDR_PROC_STATUS, 8'h10);
    repeat (4) rd(8'h27 + 8'($urandom_range(0, 200)), 8'h00);
    v = {1'b1, 7'($urandom)};
    u_cpu_io_model.io_op(1'b0, 1'b1, 1'b1, 8'h00, ADDR_USB_ADDR_A, v);
    tick(2);
    check(o_usb_addr, v);
    check(o_usb_tx_en, 1'b1);
    rd(ADDR_USB_ADDR_A, v);
    wr(ADDR_PROC_STATUS, 8'h00);
    // clears spaced under one tick period keep the core running
    repeat (4) begin
        tick(3000);
        check(o_cpu_rst_b, 1'b1);
        wr(ADDR_WDOG_CLEAR, 8'($urandom));
    end
    wait_cpu(1'b0, 9000);
    check(n >= 4090, 1'b1);
    wait_cpu(1'b1, 40);
    check(n >= 8, 1'b1);
    check(o_usb_addr, 8'h00);
    check(o_usb_tx_en, 1'b0);
    rd(ADDR_PROC_STATUS, 8'h40);
    wr(ADDR_USB_ADDR_A, 8'h85);
    wr(ADDR_PROC_STATUS, 8'h00);
    @(posedge i_sys_clk);
    i_usb.bus_reset <= 1'b1;
    @(posedge i_sys_clk);
    i_usb.bus_reset <= 1'b0;
    tick(4);
    check(soft_seen, 1'b1);
    check(o_cpu_rst_b, 1'b1);
    check(o_usb_addr, 8'h00);
    rd(ADDR_PROC_STATUS, 8'h20);
    // suspend, then wake with strap kept high or pulled low
    for (int s = 1; s >= 0; s--) begin
        por(1'b1, IDLE);
        tick(4);
        check(o_suspend, 1'b1);
        @(posedge i_sys_clk);
        i_strap_p3_7 <= 1'(s);
        i_usb <= KRES;
        wait_cpu(1'b1, 60);
        check(n >= 20, !1'(s));
    end
    // strap high with a busy bus skips suspend and takes the short delay
    por(1'b1, KRES);
    wait_cpu(1'b1, 60);
    check(n < 20, 1'b1);
    check(o_suspend, 1'b0);
    tick(4);
    // every read request must have produced its result
    check(16'(exp_q.size()), 16'h0000);
    print_verdict();
end
endmodule
bind reset_and_watchdog_control rst_wdog_sva #(.SHORT_CYC(SHORT_CYC)) u_rst_wdog_sva (
    .i_sys_clk, .i_rst_b, .i_io, .i_usb, .o_rd_data, .o_cpu_rst_b, .o_soft_rst,
    .o_start_addr, .o_prog_stack_ptr, .o_data_stack_ptr, .o_gpio_hiz, .o_suspend,
    .o_usb_tx_en, .o_usb_addr);
